// ===== cgpm_top.sv
/*
  Clock generator and power management register block: peripheral clock
  gates, oscillator and PLL start-up timing, main clock measurement and
  master clock selection.
  Assumes slow_clk_tick and main_clk_tick are one-cycle pulses already
  synchronous to ref_clk, one per slow or main clock period.
*/
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps

// ******************************************************************
// Start-up timer counting slow clock ticks
// ******************************************************************
module cgpm_startup_timer #(
  parameter int TW = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic restart,
  input wire logic tick,
  input wire logic [TW-1:0] target,
  output logic done
);
  logic [TW-1:0] cnt_q;
  logic done_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!en || restart) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q >= target) begin
        done_q <= 1'b1;
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign done = done_q;
endmodule : cgpm_startup_timer

// ******************************************************************
// Top level
// ******************************************************************
module cgpm_top #(
  parameter logic [31:0] PERIPH_IMPL = cgpm_pkg::PERIPH_IMPL_DEF,
  parameter int RC_STARTUP_SLOW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow_clk_tick,
  input wire logic main_clk_tick,
  input wire logic [cgpm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output cgpm_pkg::cgpm_clk_ctrl_t clk_ctrl,
  output cgpm_pkg::cgpm_status_t status
);
  localparam int TW = cgpm_pkg::TIMER_W;

  logic [31:0] periph_q;
  cgpm_pkg::cgpm_phy_pll_t phy_q;
  cgpm_pkg::cgpm_main_osc_t osc_q;
  cgpm_pkg::cgpm_main_pll_t pll_q;
  cgpm_pkg::cgpm_master_t mck_q;
  cgpm_pkg::cgpm_freq_t freq_q;
  cgpm_pkg::cgpm_meas_t meas_q;
  logic [4:0] meas_slow_q;
  logic [15:0] meas_cnt_q;
  logic [31:0] rdata_q;
  cgpm_pkg::cgpm_clk_ctrl_t ctrl_q;
  cgpm_pkg::cgpm_main_osc_t osc_wr;
  logic wr_periph_en;
  logic wr_periph_dis;
  logic wr_phy;
  logic wr_osc;
  logic wr_pll;
  logic wr_mck;
  logic osc_key_ok;
  logic pll_mul_on;
  logic pll_div_on;
  logic meas_last;
  logic phy_done, bias_done, xtal_done, rc_done, pll_done;
  logic main_osc_on;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // One strobe qualified by one register offset
  function automatic logic wr_hit(
    input logic strobe,
    input logic [cgpm_pkg::ADDR_W-1:0] addr,
    input logic [cgpm_pkg::ADDR_W-1:0] ofs
  );
    wr_hit = strobe && (addr == ofs);
  endfunction : wr_hit

  // PHY PLL and crystal start-up counts in units of eight slow ticks
  function automatic logic [TW-1:0] times_eight(input logic [TW-1:0] cnt);
    times_eight = cnt << cgpm_pkg::STARTUP_SHIFT;
  endfunction : times_eight

  assign osc_wr = cgpm_pkg::cgpm_main_osc_t'(reg_wdata);
  assign wr_periph_en = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_PERIPH_EN);
  assign wr_periph_dis = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_PERIPH_DIS);
  assign wr_phy = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_PHY_PLL);
  assign wr_osc = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_MAIN_OSC);
  assign wr_pll = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_MAIN_PLL);
  assign wr_mck = wr_hit(reg_wr, reg_addr, cgpm_pkg::OFS_MASTER);
  assign osc_key_ok = osc_wr.password == cgpm_pkg::OSC_PASSWORD;
  assign pll_mul_on = pll_q.mul != '0;
  assign pll_div_on = pll_q.div != '0;

  // ****************************************************************
  // Peripheral clock gates
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_q <= '0;
    end else if (wr_periph_en) begin
      periph_q <= periph_q | (reg_wdata & PERIPH_IMPL);
    end else if (wr_periph_dis) begin
      periph_q <= periph_q & ~(reg_wdata & PERIPH_IMPL);
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_q <= cgpm_pkg::PHY_PLL_RST;
    end else if (wr_phy) begin
      phy_q <= '0;
      phy_q.pll_en <= reg_wdata[16];
      phy_q.pll_cnt <= reg_wdata[23:20];
      phy_q.bias_en <= reg_wdata[24];
      phy_q.bias_cnt <= reg_wdata[31:28];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= cgpm_pkg::MAIN_OSC_RST;
    end else if (wr_osc && osc_key_ok) begin
      osc_q <= '0;
      osc_q.xtal_en <= osc_wr.xtal_en;
      osc_q.xtal_bypass <= osc_wr.xtal_bypass;
      osc_q.rc_en <= osc_wr.rc_en;
      osc_q.xtal_cnt <= osc_wr.xtal_cnt;
      osc_q.src_crystal <= osc_wr.src_crystal;
      osc_q.cfd_en <= osc_wr.cfd_en;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_q <= cgpm_pkg::MAIN_PLL_RST;
    end else if (wr_pll) begin
      pll_q <= cgpm_pkg::cgpm_main_pll_t'(reg_wdata);
      pll_q.rsv_a <= '0;
      pll_q.rsv_b <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_q <= cgpm_pkg::MASTER_RST;
    end else if (wr_mck) begin
      mck_q <= '0;
      mck_q.src <= reg_wdata[1:0];
      mck_q.presc <= reg_wdata[6:4];
      mck_q.mck_div <= reg_wdata[9:8];
      mck_q.halve <= reg_wdata[12];
    end
  end

  // ****************************************************************
  // Start-up timers
  // ****************************************************************
  cgpm_startup_timer #(.TW(TW)) u_phy_pll (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(phy_q.pll_en),
    .restart(1'b0),
    .tick(slow_clk_tick),
    .target(times_eight(TW'(phy_q.pll_cnt))),
    .done(phy_done)
  );

  cgpm_startup_timer #(.TW(TW)) u_bias (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(phy_q.bias_en),
    .restart(1'b0),
    .tick(slow_clk_tick),
    .target(TW'(phy_q.bias_cnt)),
    .done(bias_done)
  );

  cgpm_startup_timer #(.TW(TW)) u_xtal (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(osc_q.xtal_en),
    .restart(1'b0),
    .tick(slow_clk_tick),
    .target(times_eight(TW'(osc_q.xtal_cnt))),
    .done(xtal_done)
  );

  cgpm_startup_timer #(.TW(TW)) u_rc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(osc_q.rc_en),
    .restart(1'b0),
    .tick(slow_clk_tick),
    .target(TW'(RC_STARTUP_SLOW)),
    .done(rc_done)
  );

  cgpm_startup_timer #(.TW(TW)) u_main_pll (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(pll_mul_on),
    .restart(wr_pll),
    .tick(slow_clk_tick),
    .target(TW'(pll_q.lock_cnt)),
    .done(pll_done)
  );

  always_comb begin
    status = '0;
    status.phy_locked = phy_done;
    status.xtal_stable = xtal_done || osc_q.xtal_bypass;
    status.rc_stable = rc_done;
    status.pll_locked = pll_done;
  end

  // ****************************************************************
  // Main clock frequency measurement
  // ****************************************************************
  assign main_osc_on = osc_q.src_crystal ? (osc_q.xtal_en || osc_q.xtal_bypass)
                                         : osc_q.rc_en;
  assign meas_last = slow_clk_tick && (meas_slow_q == 5'(cgpm_pkg::MEAS_PERIODS - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_q <= cgpm_pkg::CGPM_MEAS_IDLE;
      meas_slow_q <= '0;
      meas_cnt_q <= '0;
      freq_q <= '0;
    end else if (!main_osc_on) begin
      meas_q <= cgpm_pkg::CGPM_MEAS_IDLE;
      freq_q.valid <= 1'b0;
    end else begin
      unique case (meas_q)
        cgpm_pkg::CGPM_MEAS_IDLE: begin
          meas_q <= cgpm_pkg::CGPM_MEAS_ALIGN;
        end
        cgpm_pkg::CGPM_MEAS_ALIGN: begin
          meas_slow_q <= '0;
          meas_cnt_q <= '0;
          if (slow_clk_tick) begin
            meas_q <= cgpm_pkg::CGPM_MEAS_COUNT;
          end
        end
        cgpm_pkg::CGPM_MEAS_COUNT: begin
          if (main_clk_tick) begin
            meas_cnt_q <= meas_cnt_q + 1'b1;
          end
          if (meas_last) begin
            meas_q <= cgpm_pkg::CGPM_MEAS_DONE;
            freq_q.count <= meas_cnt_q + 16'(main_clk_tick);
            freq_q.valid <= 1'b1;
          end
          if (slow_clk_tick) begin
            meas_slow_q <= meas_slow_q + 1'b1;
          end
        end
        cgpm_pkg::CGPM_MEAS_DONE: begin
          meas_q <= cgpm_pkg::CGPM_MEAS_DONE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Clock tree controls
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q.periph_on <= periph_q;
      ctrl_q.phy_pll_on <= phy_q.pll_en;
      ctrl_q.phy_bias_on <= phy_q.bias_en && bias_done;
      ctrl_q.crystal_on <= osc_q.xtal_en;
      ctrl_q.crystal_bypass <= osc_q.xtal_bypass;
      ctrl_q.fast_rc_on <= osc_q.rc_en;
      ctrl_q.main_src_crystal <= osc_q.src_crystal;
      ctrl_q.cfd_on <= osc_q.cfd_en;
      ctrl_q.main_pll_on <= pll_mul_on && pll_div_on;
      ctrl_q.pll_div <= pll_q.div;
      ctrl_q.pll_ratio <= 12'(pll_q.mul) + 12'h001;
      ctrl_q.pll_halve <= mck_q.halve;
      ctrl_q.master_src <= cgpm_pkg::cgpm_src_t'(mck_q.src);
      ctrl_q.presc_ratio <= cgpm_pkg::presc_ratio(mck_q.presc);
      ctrl_q.mck_div_ratio <= cgpm_pkg::mck_div_ratio(mck_q.mck_div);
      ctrl_q.memory_clk_avail <= mck_q.mck_div != 2'h0;
    end
  end

  assign clk_ctrl = ctrl_q;

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        cgpm_pkg::OFS_PERIPH_STAT: rdata_q <= periph_q;
        cgpm_pkg::OFS_PHY_PLL: rdata_q <= phy_q;
        cgpm_pkg::OFS_MAIN_OSC: rdata_q <= osc_q;
        cgpm_pkg::OFS_FREQ: rdata_q <= freq_q;
        cgpm_pkg::OFS_MAIN_PLL: rdata_q <= pll_q;
        cgpm_pkg::OFS_MASTER: rdata_q <= mck_q;
        cgpm_pkg::OFS_STATUS: rdata_q <= status;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : cgpm_top

// ===== cgpm_pkg.sv
/*
  Constants, register layouts and helpers for the clock generator and
  power management register block.
  Assumes one 200 MHz ref_clk domain and a register port with 8-bit
  byte addresses and 32-bit data.
*/
package cgpm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PERIPH_EN = 8'h10;
  localparam logic [7:0] OFS_PERIPH_DIS = 8'h14;
  localparam logic [7:0] OFS_PERIPH_STAT = 8'h18;
  localparam logic [7:0] OFS_PHY_PLL = 8'h1C;
  localparam logic [7:0] OFS_MAIN_OSC = 8'h20;
  localparam logic [7:0] OFS_FREQ = 8'h24;
  localparam logic [7:0] OFS_MAIN_PLL = 8'h28;
  localparam logic [7:0] OFS_MASTER = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h68;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [7:0] OSC_PASSWORD = 8'h37;
  localparam int STARTUP_SHIFT = 3;
  localparam int MEAS_PERIODS = 16;
  localparam int TIMER_W = 12;
  localparam logic [31:0] PERIPH_IMPL_DEF = 32'hFFFF_FFFC;

  // ****************************************************************
  // Register layouts
  // ****************************************************************
  typedef struct packed {
    logic [3:0] bias_cnt;
    logic [2:0] rsv_b;
    logic bias_en;
    logic [3:0] pll_cnt;
    logic [2:0] rsv_a;
    logic pll_en;
    logic [15:0] rsv;
  } cgpm_phy_pll_t;

  typedef struct packed {
    logic [5:0] rsv_c;
    logic cfd_en;
    logic src_crystal;
    logic [7:0] password;
    logic [7:0] xtal_cnt;
    logic [3:0] rsv_b;
    logic rc_en;
    logic rsv_a;
    logic xtal_bypass;
    logic xtal_en;
  } cgpm_main_osc_t;

  typedef struct packed {
    logic [14:0] rsv;
    logic valid;
    logic [15:0] count;
  } cgpm_freq_t;

  typedef struct packed {
    logic [1:0] rsv_b;
    logic must_one;
    logic [1:0] rsv_a;
    logic [10:0] mul;
    logic [1:0] range;
    logic [5:0] lock_cnt;
    logic [7:0] div;
  } cgpm_main_pll_t;

  typedef struct packed {
    logic [18:0] rsv_d;
    logic halve;
    logic [1:0] rsv_c;
    logic [1:0] mck_div;
    logic rsv_b;
    logic [2:0] presc;
    logic [1:0] rsv_a;
    logic [1:0] src;
  } cgpm_master_t;

  typedef struct packed {
    logic [13:0] rsv_c;
    logic rc_stable;
    logic [9:0] rsv_b;
    logic phy_locked;
    logic [3:0] rsv_a;
    logic pll_locked;
    logic xtal_stable;
  } cgpm_status_t;

  localparam cgpm_phy_pll_t PHY_PLL_RST = 32'h1020_0000;
  localparam cgpm_main_osc_t MAIN_OSC_RST = 32'h0100_0008;
  localparam cgpm_main_pll_t MAIN_PLL_RST = 32'h0000_3F00;
  localparam cgpm_master_t MASTER_RST = 32'h0000_0001;

  typedef enum logic [1:0] {
    CGPM_SRC_SLOW = 2'h0,
    CGPM_SRC_MAIN = 2'h1,
    CGPM_SRC_MAIN_PLL = 2'h2,
    CGPM_SRC_PHY_PLL = 2'h3
  } cgpm_src_t;

  typedef enum logic [1:0] {
    CGPM_MEAS_IDLE = 2'h0,
    CGPM_MEAS_ALIGN = 2'h1,
    CGPM_MEAS_COUNT = 2'h2,
    CGPM_MEAS_DONE = 2'h3
  } cgpm_meas_t;

  // Clock controls driven to the clock tree
  typedef struct packed {
    logic [31:0] periph_on;
    logic phy_pll_on;
    logic phy_bias_on;
    logic crystal_on;
    logic crystal_bypass;
    logic fast_rc_on;
    logic main_src_crystal;
    logic cfd_on;
    logic main_pll_on;
    logic [7:0] pll_div;
    logic [11:0] pll_ratio;
    logic pll_halve;
    cgpm_src_t master_src;
    logic [6:0] presc_ratio;
    logic [2:0] mck_div_ratio;
    logic memory_clk_avail;
  } cgpm_clk_ctrl_t;

  // ****************************************************************
  // Ratio decoding
  // ****************************************************************
  function automatic logic [6:0] presc_ratio(input logic [2:0] code);
    presc_ratio = (code == 3'h7) ? 7'h03 : 7'(7'h01 << code);
  endfunction : presc_ratio

  function automatic logic [2:0] mck_div_ratio(input logic [1:0] div_code);
    unique case (div_code)
      2'h0: mck_div_ratio = 3'h1;
      2'h1: mck_div_ratio = 3'h2;
      2'h2: mck_div_ratio = 3'h4;
      2'h3: mck_div_ratio = 3'h3;
    endcase
  endfunction : mck_div_ratio

endpackage : cgpm_pkg

// ===== cgpm_asserts.sv
/*
  Concurrent checks on the clock block register port and clock controls.
  Assumes binding to cgpm_top and one ref_clk domain with rst_n.
*/
`timescale 1ns/10ps
module cgpm_asserts #(
  parameter logic [31:0] PERIPH_IMPL = 32'hFFFF_FFFC,
  parameter int RC_STARTUP_SLOW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow_clk_tick,
  input wire logic main_clk_tick,
  input wire logic [cgpm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire cgpm_pkg::cgpm_clk_ctrl_t clk_ctrl,
  input wire cgpm_pkg::cgpm_status_t status
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Write sequences
  // ****************************************************************
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence osc_good;
    wr_at(cgpm_pkg::OFS_MAIN_OSC) ##0 reg_wdata[23:16] == cgpm_pkg::OSC_PASSWORD;
  endsequence
  sequence osc_bad;
    wr_at(cgpm_pkg::OFS_MAIN_OSC) ##0 reg_wdata[23:16] != cgpm_pkg::OSC_PASSWORD;
  endsequence

  // ****************************************************************
  // Properties
  // ****************************************************************
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  periph_on_a: assert property (wr_at(cgpm_pkg::OFS_PERIPH_EN) |-> ##2
    ((clk_ctrl.periph_on & $past(reg_wdata, 2) & PERIPH_IMPL)
      == ($past(reg_wdata, 2) & PERIPH_IMPL)))
    else $error("enabled peripheral clock not on");
  periph_off_a: assert property (wr_at(cgpm_pkg::OFS_PERIPH_DIS) |-> ##2
    ((clk_ctrl.periph_on & $past(reg_wdata, 2)) == 32'h0))
    else $error("disabled peripheral clock still on");
  periph_impl_a: assert property ((clk_ctrl.periph_on & ~PERIPH_IMPL) == 32'h0)
    else $error("unimplemented peripheral clock on");
  bad_key_a: assert property (osc_bad |-> ##2 $stable({clk_ctrl.crystal_on,
    clk_ctrl.crystal_bypass, clk_ctrl.fast_rc_on, clk_ctrl.main_src_crystal}))
    else $error("oscillator write without key took effect");
  bypass_flag_a: assert property (osc_good ##0 reg_wdata[1] |-> ##[1:2]
    status.xtal_stable) else $error("bypass did not set crystal stable");
  xtal_clear_a: assert property (osc_good ##0 reg_wdata[1:0] == 2'h0
    ##1 !(reg_wr && reg_addr == cgpm_pkg::OFS_MAIN_OSC) |=> !status.xtal_stable)
    else $error("crystal stable not cleared");
  lock_drop_a: assert property (wr_at(cgpm_pkg::OFS_MAIN_PLL) |=>
    !status.pll_locked) else $error("main PLL lock kept over a write");
  pll_ratio_a: assert property (wr_at(cgpm_pkg::OFS_MAIN_PLL) |-> ##2
    (clk_ctrl.pll_ratio == 12'($past(reg_wdata[26:16], 2)) + 12'h001))
    else $error("main PLL ratio wrong");
  master_src_a: assert property (wr_at(cgpm_pkg::OFS_MASTER) |-> ##2
    (clk_ctrl.master_src == $past(reg_wdata[1:0], 2)
      && clk_ctrl.memory_clk_avail == ($past(reg_wdata[9:8], 2) != 2'h0)))
    else $error("master source or memory clock wrong");
endmodule : cgpm_asserts

bind cgpm_top cgpm_asserts #(.PERIPH_IMPL(PERIPH_IMPL), .RC_STARTUP_SLOW(RC_STARTUP_SLOW))
  cgpm_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow_clk_tick(slow_clk_tick),
  .main_clk_tick(main_clk_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_ctrl(clk_ctrl),
  .status(status));

// ===== tb.sv
/*
  Self-checking bench for the clock block.
  Assumes the package and cgpm_top; slow tick every 4 cycles, main every 2.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] IMPL = 32'hFFFF_FFFC;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_clk_tick = 1'b0;
  logic main_clk_tick = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  cgpm_pkg::cgpm_clk_ctrl_t clk_ctrl;
  cgpm_pkg::cgpm_status_t status;
  int fails = 0;
  int n_checks = 0;
  int seed = 89;
  int cyc = 0;
  int n;
  logic [31:0] model;
  logic [31:0] w;
  logic [31:0] got;

  cgpm_top #(.PERIPH_IMPL(IMPL), .RC_STARTUP_SLOW(2)) cgpm_top_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .slow_clk_tick(slow_clk_tick), .main_clk_tick(main_clk_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_ctrl(clk_ctrl), .status(status));

  // ****************************************************************
  // Clock, ticks and bus tasks
  // ****************************************************************
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    slow_clk_tick <= (cyc % 4 == 3);
    main_clk_tick <= (cyc % 2 == 1);
  end

  function automatic logic [31:0] pr(input logic [2:0] p);
    return (p == 3'h7) ? 32'h3 : (32'h1 << p);
  endfunction : pr

  function automatic logic [31:0] md(input logic [1:0] m);
    return (m == 2'h3) ? 32'h3 : (32'h1 << m);
  endfunction : md

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rc

  // Counts slow ticks until flag b of {bias on, status} rises
  task automatic ticks_to(input int b, input int t, input string nm);
    int k;
    logic [32:0] v;
    k = 0;
    v = 33'h0;
    for (int c = 0; c < 2000 && v[b] !== 1'b1; c++) begin
      @(posedge ref_clk);
      if (slow_clk_tick)
        k++;
      #1 v = {clk_ctrl.phy_bias_on, status};
    end
    n_checks++;
    if (!(v[b] === 1'b1 && k >= t - 1 && k <= t + 1)) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", nm, t, k);
    end
  endtask : ticks_to

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc("phy_cfg", cgpm_pkg::OFS_PHY_PLL, 32'h1020_0000);
    rc("osc_cfg", cgpm_pkg::OFS_MAIN_OSC, 32'h0100_0008);
    rc("pll_cfg", cgpm_pkg::OFS_MAIN_PLL, 32'h0000_3F00);
    rc("master_cfg", cgpm_pkg::OFS_MASTER, 32'h0000_0001);
    rc("periph_stat", cgpm_pkg::OFS_PERIPH_STAT, 32'h0);
    rc("wo_read", cgpm_pkg::OFS_PERIPH_EN, 32'h0);
    rc("hole", 8'h2C, 32'h0);
    $display("test reset values done");
    model = 32'h0;
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      n = $random(seed);
      if (n[0] || i == 0) begin
        wr(cgpm_pkg::OFS_PERIPH_EN, w);
        model = model | (w & IMPL);
      end else begin
        wr(cgpm_pkg::OFS_PERIPH_DIS, w);
        model = model & ~w;
      end
      rc("periph_stat", cgpm_pkg::OFS_PERIPH_STAT, model);
      chk("periph_on", model, clk_ctrl.periph_on);
    end
    wr(cgpm_pkg::OFS_PERIPH_EN, 32'hFFFF_FFFF);
    wr(cgpm_pkg::OFS_PERIPH_DIS, 32'h0000_FFFF);
    rc("periph_stat", cgpm_pkg::OFS_PERIPH_STAT, 32'hFFFF_0000);
    $display("test peripheral gates done");
    wr(cgpm_pkg::OFS_MAIN_OSC, 32'h0037_0008);
    repeat (100) @(posedge ref_clk);
    rd(cgpm_pkg::OFS_FREQ, got);
    chk("freq_valid", 32'h1, got[16]);
    n = 16 * 4 / 2;
    chk("freq_count", 32'h1, (got[15:0] >= n - 1 && got[15:0] <= n + 1));
    rd(cgpm_pkg::OFS_STATUS, got);
    chk("rc_stable", 32'h1, got[17]);
    wr(cgpm_pkg::OFS_MAIN_OSC, 32'h0012_0003);
    rc("osc_cfg", cgpm_pkg::OFS_MAIN_OSC, 32'h0000_0008);
    wr(cgpm_pkg::OFS_MAIN_OSC, 32'h0037_000A);
    rd(cgpm_pkg::OFS_STATUS, got);
    chk("bypass_stable", 32'h1, got[0]);
    chk("bypass_on", 32'h1, clk_ctrl.crystal_bypass);
    wr(cgpm_pkg::OFS_MAIN_OSC, 32'h0037_0000);
    repeat (4) @(posedge ref_clk);
    rd(cgpm_pkg::OFS_STATUS, got);
    chk("xtal_cleared", 32'h0, got[0]);
    chk("rc_off", 32'h0, clk_ctrl.fast_rc_on);
    rd(cgpm_pkg::OFS_FREQ, got);
    chk("freq_dropped", 32'h0, got[16]);
    wr(cgpm_pkg::OFS_MAIN_OSC, 32'h0337_0209);
    ticks_to(0, 16, "xtal_time");
    chk("detector_on", 32'h1, clk_ctrl.cfd_on);
    chk("src_crystal", 32'h1, clk_ctrl.main_src_crystal);
    chk("crystal_on", 32'h1, clk_ctrl.crystal_on);
    $display("test oscillators done");
    wr(cgpm_pkg::OFS_PHY_PLL, 32'h3100_0000);
    ticks_to(32, 3, "bias_time");
    wr(cgpm_pkg::OFS_PHY_PLL, 32'h3111_0000);
    ticks_to(6, 8, "phy_lock_time");
    chk("phy_pll_on", 32'h1, clk_ctrl.phy_pll_on);
    wr(cgpm_pkg::OFS_PHY_PLL, 32'h3100_0000);
    rd(cgpm_pkg::OFS_STATUS, got);
    chk("phy_unlocked", 32'h0, got[6]);
    chk("phy_pll_off", 32'h0, clk_ctrl.phy_pll_on);
    $display("test phy PLL done");
    wr(cgpm_pkg::OFS_MAIN_PLL, 32'h2001_0501);
    ticks_to(1, 5, "pll_lock_time");
    for (int i = 0; i < 10; i++) begin
      w = ($random(seed) & 32'h07FF_FFFF) | 32'h2000_0000;
      if (i == 0)
        w = 32'h2000_0000;
      if (i == 1)
        w = 32'h20FE_3F01;
      if (i == 2)
        w = 32'h20FE_0000;
      wr(cgpm_pkg::OFS_MAIN_PLL, w);
      rc("pll_cfg", cgpm_pkg::OFS_MAIN_PLL, w);
      chk("pll_on", (w[26:16] != 0 && w[7:0] != 0), clk_ctrl.main_pll_on);
      chk("pll_ratio", 32'(w[26:16]) + 32'h1, clk_ctrl.pll_ratio);
      chk("pll_div", w[7:0], clk_ctrl.pll_div);
    end
    $display("test main PLL done");
    for (int i = 0; i < 8; i++) begin
      w = $random(seed) & 32'h0000_1373;
      w[1:0] = i[1:0];
      w[6:4] = i[2:0];
      w[9:8] = ~i[1:0];
      wr(cgpm_pkg::OFS_MASTER, w);
      rc("master_cfg", cgpm_pkg::OFS_MASTER, w);
      chk("master_src", w[1:0], clk_ctrl.master_src);
      chk("presc", pr(w[6:4]), clk_ctrl.presc_ratio);
      chk("mck_div", md(w[9:8]), clk_ctrl.mck_div_ratio);
      chk("mem_clk", w[9:8] != 2'h0, clk_ctrl.memory_clk_avail);
      chk("halve", w[12], clk_ctrl.pll_halve);
    end
    $display("test master clock done");
    tally_and_finish();
  end
endmodule : tb
